// ===== bench/dam_area_map_sva.sv
/* Checker for the data area map program and system ports.
   Assumes the synchronous active-high reset and one clock of the block. */
`timescale 1ns/1ps
module dam_area_map_sva (
  input logic i_clk,
  input logic i_rst,
  input logic i_req,
  input dam_pkg::dam_op_type i_op,
  input dam_pkg::dam_area_type i_area,
  input logic [dam_pkg::ADDR_W-1:0] i_word,
  input logic [3:0] i_bit,
  input logic i_sys_we,
  input logic [3:0] i_sys_word,
  input logic [dam_pkg::WORD_W-1:0] i_sys_mask,
  input logic [dam_pkg::WORD_W-1:0] i_sys_data,
  input logic o_ack,
  input logic o_invalid,
  input logic [dam_pkg::WORD_W-1:0] o_rdata,
  input logic o_rbit,
  input logic [dam_pkg::SR_WORDS*dam_pkg::WORD_W-1:0] o_system_area
);
  import dam_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire word_op = (i_op == OP_READ_WORD) || (i_op == OP_WRITE_WORD);
  wire temp_req = i_req && (i_area == AREA_TEMP);
  a_ack_follows: assert property (i_req |=> o_ack) else $error("no ack");
  a_ack_only_req: assert property (!i_req |=> !o_ack) else $error("stray ack");
  a_temp_no_word: assert property (temp_req && word_op |=> o_invalid)
    else $error("temp word op accepted");
  a_temp_load_out: assert property
    (temp_req && !(i_op inside {OP_LOAD_BIT, OP_OUT_BIT}) |=> o_invalid)
    else $error("temp op accepted");
  a_sys_top_bits: assert property (i_req && i_area == AREA_PLAIN && i_word == SR_LAST_WORD
    && !word_op && i_bit > SR_LAST_WORD_TOP_BIT |=> o_invalid) else $error("bit past 25507");
  a_data_range: assert property (i_req && i_area == AREA_DATA
    && (int'(i_word) >= DM_WORDS || !word_op) |=> o_invalid) else $error("data access accepted");
  a_plain_range: assert property (i_req && i_area == AREA_PLAIN && i_word > SR_LAST_WORD
    |=> o_invalid) else $error("plain word past 255 accepted");
  a_flag_sets: assert property (i_sys_we && i_sys_word == 4'h0 && i_sys_mask[0]
    |=> o_system_area[0] == $past(i_sys_data[0])) else $error("flag not taken");
  a_last_word_top: assert property (o_system_area[143:136] == 8'h00)
    else $error("upper byte of word 255");
  a_invalid_quiet: assert property (o_ack && o_invalid |-> o_rdata == 16'h0000 && !o_rbit)
    else $error("data on invalid");
  c_timer_bit: cover property (i_req && i_area == AREA_TIMER && i_op == OP_READ_BIT);
  c_temp_out: cover property (temp_req && i_op == OP_OUT_BIT);
  c_flag_write: cover property (i_sys_we && i_sys_mask[0]);
endmodule
bind dam_area_map dam_area_map_sva dam_area_map_sva_i (.i_clk, .i_rst, .i_req, .i_op, .i_area,
  .i_word, .i_bit, .i_sys_we, .i_sys_word, .i_sys_mask, .i_sys_data, .o_ack, .o_invalid,
  .o_rdata, .o_rbit, .o_system_area);

// ===== bench/dam_area_map_tb.sv
/* Self-checking bench for the data area map.
   Drives every port itself; one 100 MHz clock, synchronous reset. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module dam_area_map_tb;
  import dam_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_stopped = 1'b0, i_req = 1'b0, i_bit_wdata = 1'b0;
  dam_op_type i_op = OP_READ_WORD;
  dam_area_type i_area = AREA_PLAIN;
  logic [ADDR_W-1:0] i_word = '0, i_dm_load_idx = '0;
  logic [3:0] i_bit = '0, i_sys_word = '0;
  logic [WORD_W-1:0] i_wdata = '0, i_sys_mask = '0, i_sys_data = '0, i_tc_pv = '0;
  logic [WORD_W-1:0] i_dm_load_data = '0;
  logic i_sys_we = 1'b0, i_tc_flag_we = 1'b0, i_tc_flag = 1'b0, i_tc_pv_we = 1'b0;
  logic i_dm_load_we = 1'b0;
  logic [8:0] i_tc_flag_idx = '0, i_tc_pv_idx = '0;
  logic o_ack, o_invalid, o_rbit;
  logic [WORD_W-1:0] o_rdata;
  logic [SR_WORDS*WORD_W-1:0] o_system_area;
  int fail_count = 0;
  int checks_done = 0;
  dam_area_type ar_l[3] = '{AREA_AUX, AREA_HOLD, AREA_LINK};
  int last_l[3] = '{27, 99, 63};
  always #5 i_clk = ~i_clk;
  dam_area_map dam_area_map_i (.*);
  task automatic acc(input dam_op_type op, input dam_area_type ar, input int w, b,
                     input logic [15:0] wd, input logic bw, inv);
    @(posedge i_clk);
    i_req <= 1'b1;
    i_op <= op;
    i_area <= ar;
    i_word <= w[10:0];
    i_bit <= b[3:0];
    i_wdata <= wd;
    i_bit_wdata <= bw;
    @(posedge i_clk);
    i_req <= 1'b0;
    #1;
    `CHK("ack", 1'b1, o_ack)
    `CHK("invalid", inv, o_invalid)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  task automatic test_reset();
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    `CHK("sys_rst", '0, o_system_area)
    $display("test reset done");
  endtask
  task automatic test_plain();
    acc(OP_WRITE_WORD, AREA_PLAIN, 246, 0, 16'h1234, 1'b0, 1'b0);
    acc(OP_READ_WORD, AREA_PLAIN, 246, 0, 16'h0, 1'b0, 1'b0);
    `CHK("ir246", 16'h1234, o_rdata)
    acc(OP_WRITE_WORD, AREA_PLAIN, 247, 0, 16'hFFFF, 1'b0, 1'b0);
    `CHK("sr247", 16'hFF00, o_system_area[15:0])
    acc(OP_READ_BIT, AREA_PLAIN, 255, 8, 16'h0, 1'b0, 1'b1);
    acc(OP_READ_WORD, AREA_PLAIN, 256, 0, 16'h0, 1'b0, 1'b1);
    @(posedge i_clk);
    i_stopped <= 1'b1;
    @(posedge i_clk);
    i_stopped <= 1'b0;
    acc(OP_READ_WORD, AREA_PLAIN, 246, 0, 16'h0, 1'b0, 1'b0);
    `CHK("ir_stop", 16'h0000, o_rdata)
    $display("test plain done");
  endtask
  task automatic test_timer();
    @(posedge i_clk);
    {i_tc_flag_we, i_tc_pv_we, i_dm_load_we, i_tc_flag} <= 4'hF;
    {i_tc_flag_idx, i_tc_pv_idx, i_tc_pv} <= {9'h1FF, 9'h1FF, 16'h0042};
    {i_dm_load_idx, i_dm_load_data} <= {11'h3E8, 16'hA5A5};
    @(posedge i_clk);
    {i_tc_flag_we, i_tc_pv_we, i_dm_load_we} <= 3'b000;
    acc(OP_READ_BIT, AREA_TIMER, 511, 0, 16'h0, 1'b0, 1'b0);
    `CHK("tc_flag", 1'b1, o_rbit)
    acc(OP_READ_WORD, AREA_TIMER, 511, 0, 16'h0, 1'b0, 1'b0);
    `CHK("tc_pv", 16'h0042, o_rdata)
    acc(OP_READ_WORD, AREA_TIMER, 512, 0, 16'h0, 1'b0, 1'b1);
    acc(OP_WRITE_BIT, AREA_TIMER, 5, 0, 16'h0, 1'b1, 1'b1);
    $display("test timer done");
  endtask
  task automatic test_areas();
    for (int k = 0; k < 3; k++) begin
      acc(OP_WRITE_WORD, ar_l[k], last_l[k], 0, 16'h8001, 1'b0, 1'b0);
      acc(OP_READ_WORD, ar_l[k], last_l[k], 0, 16'h0, 1'b0, 1'b0);
      `CHK("area_word", 16'h8001, o_rdata)
      acc(OP_READ_BIT, ar_l[k], last_l[k], 15, 16'h0, 1'b0, 1'b0);
      `CHK("area_bit15", 1'b1, o_rbit)
      acc(OP_READ_WORD, ar_l[k], last_l[k] + 1, 0, 16'h0, 1'b0, 1'b1);
    end
    acc(OP_WRITE_WORD, AREA_DATA, 999, 0, 16'h5A5A, 1'b0, 1'b0);
    acc(OP_READ_WORD, AREA_DATA, 999, 0, 16'h0, 1'b0, 1'b0);
    `CHK("dm999", 16'h5A5A, o_rdata)
    acc(OP_WRITE_WORD, AREA_DATA, 1000, 0, 16'h0000, 1'b0, 1'b0);
    acc(OP_READ_WORD, AREA_DATA, 1000, 0, 16'h0, 1'b0, 1'b0);
    `CHK("dm1000", 16'hA5A5, o_rdata)
    acc(OP_READ_WORD, AREA_DATA, 2000, 0, 16'h0, 1'b0, 1'b1);
    acc(OP_READ_BIT, AREA_DATA, 10, 3, 16'h0, 1'b0, 1'b1);
    $display("test areas done");
  endtask
  task automatic test_temp();
    acc(OP_OUT_BIT, AREA_TEMP, 7, 0, 16'h0, 1'b1, 1'b0);
    acc(OP_LOAD_BIT, AREA_TEMP, 7, 0, 16'h0, 1'b0, 1'b0);
    `CHK("temp7", 1'b1, o_rbit)
    acc(OP_OUT_BIT, AREA_TEMP, 8, 0, 16'h0, 1'b1, 1'b1);
    acc(OP_READ_WORD, AREA_TEMP, 0, 0, 16'h0, 1'b0, 1'b1);
    acc(OP_WRITE_BIT, AREA_TEMP, 0, 0, 16'h0, 1'b1, 1'b1);
    $display("test temp done");
  endtask
  task automatic test_flags();
    @(posedge i_clk);
    {i_sys_we, i_sys_word, i_sys_mask, i_sys_data} <= {1'b1, 4'h0, 16'h0001, 16'h0001};
    @(posedge i_clk);
    i_sys_we <= 1'b0;
    #1;
    `CHK("flag_set", 1'b1, o_system_area[0])
    acc(OP_WRITE_BIT, AREA_PLAIN, 247, 0, 16'h0, 1'b0, 1'b0);
    `CHK("flag_kept", 1'b1, o_system_area[0])
    acc(OP_WRITE_BIT, AREA_PLAIN, 247, 8, 16'h0, 1'b0, 1'b0);
    `CHK("ctrl_bit", 1'b0, o_system_area[8])
    $display("test flags done");
  endtask
  initial begin
    test_reset();
    test_plain();
    test_timer();
    test_areas();
    test_temp();
    test_flags();
    report_and_stop();
  end
endmodule

// ===== src/dam_area_map.sv
/*
 * Data area map of a small programmable controller: decodes program
 * accesses by area, word and bit, holds every area, answers one cycle later.
 * Assumes the timer engine and system logic sit on the same clock.
 */
`timescale 1ns/1ps
// Behaviour
// - Internal work area words 000-246, bits to 24615, read and write.
// - System area words 247-255; last word has only bits 00-07.
// - Auxiliary area words 00-27, bit addressable, kept through reset.
// - Data memory words 0000-0999 are read and write.
// - Data memory words 1000-1999 ignore program writes.
// - Holding area words 00-99, bit addressable, kept through reset.
// - Link area words 00-63, bit addressable, free work bits.
// - Timer numbers 000-511; bit operand returns completion flag.
// - Timer number as word operand accesses the present value.
// - Eight temporary bits 00-07, never addressable as a word.
// - Temporary bits accepted only by load and output operations.
// - System logic sets and clears flag bits regardless of program.
// - Program writes to flag bits ignored; only control bits writable.
// - Unused bits and words of writable areas serve as work storage.
// - Every word is 16 bits, bit 00 rightmost, bit 15 leftmost.
// - Internal work bits cleared on reset and when operation stops.
// - Unprefixed addresses select internal or system area by number.
module dam_area_map (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stopped,
  input wire logic i_req,
  input wire dam_pkg::dam_op_type i_op,
  input wire dam_pkg::dam_area_type i_area,
  input wire logic [dam_pkg::ADDR_W-1:0] i_word,
  input wire logic [3:0] i_bit,
  input wire logic [dam_pkg::WORD_W-1:0] i_wdata,
  input wire logic i_bit_wdata,
  input wire logic i_sys_we,
  input wire logic [3:0] i_sys_word,
  input wire logic [dam_pkg::WORD_W-1:0] i_sys_mask,
  input wire logic [dam_pkg::WORD_W-1:0] i_sys_data,
  input wire logic i_tc_flag_we,
  input wire logic [8:0] i_tc_flag_idx,
  input wire logic i_tc_flag,
  input wire logic i_tc_pv_we,
  input wire logic [8:0] i_tc_pv_idx,
  input wire logic [dam_pkg::WORD_W-1:0] i_tc_pv,
  input wire logic i_dm_load_we,
  input wire logic [dam_pkg::ADDR_W-1:0] i_dm_load_idx,
  input wire logic [dam_pkg::WORD_W-1:0] i_dm_load_data,
  output logic o_ack,
  output logic o_invalid,
  output logic [dam_pkg::WORD_W-1:0] o_rdata,
  output logic o_rbit,
  output logic [dam_pkg::SR_WORDS*dam_pkg::WORD_W-1:0] o_system_area
);
  import dam_pkg::*;

  function automatic logic op_is_bit(input dam_op_type op);
    return (op != OP_READ_WORD) && (op != OP_WRITE_WORD);
  endfunction

  function automatic logic op_is_write(input dam_op_type op);
    return (op == OP_OUT_BIT) || (op == OP_WRITE_BIT) || (op == OP_WRITE_WORD);
  endfunction

  wire is_bit = op_is_bit(i_op);
  wire is_wr = op_is_write(i_op);
  wire plain = (i_area == AREA_PLAIN);
  wire in_ir = plain && (i_word <= IR_LAST_WORD);
  wire in_sr = plain && (i_word >= SR_FIRST_WORD) && (i_word <= SR_LAST_WORD);
  wire sr_top_bad = (i_word == SR_LAST_WORD) && is_bit && (i_bit > SR_LAST_WORD_TOP_BIT);
  wire [3:0] sr_idx = 4'(i_word - SR_FIRST_WORD);

  // Range and operand-kind checks per area
  logic valid;
  always_comb begin
    case (i_area)
      AREA_PLAIN: valid = (in_ir || in_sr) && !sr_top_bad;
      AREA_AUX: valid = (int'(i_word) < AR_WORDS);
      AREA_DATA: valid = (int'(i_word) < DM_WORDS) && !is_bit;
      AREA_HOLD: valid = (int'(i_word) < HR_WORDS);
      AREA_LINK: valid = (int'(i_word) < LR_WORDS);
      AREA_TIMER: valid = (int'(i_word) < TC_COUNT) && !(is_bit && is_wr);
      AREA_TEMP: valid = (int'(i_word) < TR_BITS)
        && ((i_op == OP_LOAD_BIT) || (i_op == OP_OUT_BIT));
      default: valid = 1'b0;
    endcase
  end

  wire go_wr = i_req && valid && is_wr;
  wire [WORD_W-1:0] wmask = is_bit ? (WORD_W'(1) << i_bit) : FULL_MASK;
  wire [WORD_W-1:0] wdata = is_bit ? {WORD_W{i_bit_wdata}} : i_wdata;

  wire we_ir = go_wr && in_ir;
  wire we_ar = go_wr && (i_area == AREA_AUX);
  wire we_hr = go_wr && (i_area == AREA_HOLD);
  wire we_lr = go_wr && (i_area == AREA_LINK);
  wire we_dm_prog = go_wr && (i_area == AREA_DATA) && (i_word <= DM_RW_LAST);
  wire we_pv_prog = go_wr && (i_area == AREA_TIMER) && !is_bit;
  wire we_sr = go_wr && in_sr;
  wire we_tr = go_wr && (i_area == AREA_TEMP);

  // Loader and timer engine take the port when they write
  wire dm_we = i_dm_load_we || we_dm_prog;
  wire [ADDR_W-1:0] dm_widx = i_dm_load_we ? i_dm_load_idx : i_word;
  wire [WORD_W-1:0] dm_wmask = i_dm_load_we ? FULL_MASK : wmask;
  wire [WORD_W-1:0] dm_wdata = i_dm_load_we ? i_dm_load_data : wdata;
  wire pv_we = i_tc_pv_we || we_pv_prog;
  wire [8:0] pv_widx = i_tc_pv_we ? i_tc_pv_idx : i_word[8:0];
  wire [WORD_W-1:0] pv_wmask = i_tc_pv_we ? FULL_MASK : wmask;
  wire [WORD_W-1:0] pv_wdata = i_tc_pv_we ? i_tc_pv : wdata;
  wire ir_clear = i_rst || i_stopped;

  wire [WORD_W-1:0] ir_word;
  wire [WORD_W-1:0] ar_word;
  wire [WORD_W-1:0] dm_word;
  wire [WORD_W-1:0] hr_word;
  wire [WORD_W-1:0] lr_word;
  wire [WORD_W-1:0] pv_word;

  dam_word_bank #(.DEPTH(IR_WORDS), .IDX_W(8)) u_ir (
    .i_clk(i_clk), .i_clear(ir_clear), .i_we(we_ir), .i_idx(i_word[7:0]),
    .i_wmask(wmask), .i_wdata(wdata), .i_ridx(i_word[7:0]), .o_rdata(ir_word)
  );
  dam_word_bank #(.DEPTH(AR_WORDS), .IDX_W(5)) u_ar (
    .i_clk(i_clk), .i_clear(1'b0), .i_we(we_ar), .i_idx(i_word[4:0]),
    .i_wmask(wmask), .i_wdata(wdata), .i_ridx(i_word[4:0]), .o_rdata(ar_word)
  );
  dam_word_bank #(.DEPTH(DM_WORDS), .IDX_W(ADDR_W)) u_dm (
    .i_clk(i_clk), .i_clear(1'b0), .i_we(dm_we), .i_idx(dm_widx),
    .i_wmask(dm_wmask), .i_wdata(dm_wdata), .i_ridx(i_word), .o_rdata(dm_word)
  );
  dam_word_bank #(.DEPTH(HR_WORDS), .IDX_W(7)) u_hr (
    .i_clk(i_clk), .i_clear(1'b0), .i_we(we_hr), .i_idx(i_word[6:0]),
    .i_wmask(wmask), .i_wdata(wdata), .i_ridx(i_word[6:0]), .o_rdata(hr_word)
  );
  dam_word_bank #(.DEPTH(LR_WORDS), .IDX_W(6)) u_lr (
    .i_clk(i_clk), .i_clear(1'b0), .i_we(we_lr), .i_idx(i_word[5:0]),
    .i_wmask(wmask), .i_wdata(wdata), .i_ridx(i_word[5:0]), .o_rdata(lr_word)
  );
  dam_word_bank #(.DEPTH(TC_COUNT), .IDX_W(9)) u_pv (
    .i_clk(i_clk), .i_clear(1'b0), .i_we(pv_we), .i_idx(pv_widx),
    .i_wmask(pv_wmask), .i_wdata(pv_wdata), .i_ridx(i_word[8:0]), .o_rdata(pv_word)
  );

  // System area: system writes win over program on shared bits
  logic [WORD_W-1:0] sr [SR_WORDS];
  genvar g;
  generate
    for (g = 0; g < SR_WORDS; g++) begin : g_sr
      wire sys_hit = i_sys_we && (i_sys_word == 4'(g));
      wire prog_hit = we_sr && (sr_idx == 4'(g));
      wire [WORD_W-1:0] exist = (g == SR_WORDS - 1) ? SR_LAST_WORD_MASK : FULL_MASK;
      wire [WORD_W-1:0] pmask = prog_hit ? (wmask & SR_USER_MASK) : WORD_RESET;
      wire [WORD_W-1:0] smask = sys_hit ? i_sys_mask : WORD_RESET;
      wire [WORD_W-1:0] after_prog = (sr[g] & ~pmask) | (wdata & pmask);
      wire [WORD_W-1:0] next_word = (after_prog & ~smask) | (i_sys_data & smask);
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          sr[g] <= WORD_RESET;
        end else begin
          sr[g] <= next_word & exist;
        end
      end
      assign o_system_area[g*WORD_W +: WORD_W] = sr[g];
    end
  endgenerate

  logic [TC_COUNT-1:0] tc_flag;
  logic [TR_BITS-1:0] tr;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tc_flag <= '0;
    end else if (i_tc_flag_we) begin
      tc_flag[i_tc_flag_idx] <= i_tc_flag;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tr <= '0;
    end else if (we_tr) begin
      tr[i_word[2:0]] <= i_bit_wdata;
    end
  end

  // Read selection
  logic [WORD_W-1:0] sel_word;
  always_comb begin
    case (i_area)
      AREA_PLAIN: sel_word = in_ir ? ir_word : sr[sr_idx];
      AREA_AUX: sel_word = ar_word;
      AREA_DATA: sel_word = dm_word;
      AREA_HOLD: sel_word = hr_word;
      AREA_LINK: sel_word = lr_word;
      AREA_TIMER: sel_word = pv_word;
      default: sel_word = WORD_RESET;
    endcase
  end

  wire sel_bit = (i_area == AREA_TIMER) ? tc_flag[i_word[8:0]] :
    (i_area == AREA_TEMP) ? tr[i_word[2:0]] : sel_word[i_bit];
  wire next_rbit = valid && is_bit && sel_bit;
  wire [WORD_W-1:0] next_rdata = (valid && !is_bit) ? sel_word : WORD_RESET;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_invalid <= 1'b0;
      o_rdata <= WORD_RESET;
      o_rbit <= 1'b0;
    end else begin
      o_ack <= i_req;
      o_invalid <= i_req && !valid;
      if (i_req) begin
        o_rdata <= next_rdata;
        o_rbit <= next_rbit;
      end
    end
  end
endmodule

// ===== src/dam_pkg.sv
/*
 * Constants, area and operation codes for the controller data area map.
 * Assumes one 100 MHz clock and a synchronous active-high reset.
 */
package dam_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 11;
  localparam logic [ADDR_W-1:0] IR_LAST_WORD = 11'h0F6;
  localparam logic [ADDR_W-1:0] SR_FIRST_WORD = 11'h0F7;
  localparam logic [ADDR_W-1:0] SR_LAST_WORD = 11'h0FF;
  localparam logic [3:0] SR_LAST_WORD_TOP_BIT = 4'h7;
  localparam int IR_WORDS = 247;
  localparam int SR_WORDS = 9;
  localparam int AR_WORDS = 28;
  localparam int DM_WORDS = 2000;
  localparam logic [ADDR_W-1:0] DM_RW_LAST = 11'h3E7;
  localparam int HR_WORDS = 100;
  localparam int LR_WORDS = 64;
  localparam int TC_COUNT = 512;
  localparam int TR_BITS = 8;
  localparam logic [WORD_W-1:0] SR_USER_MASK = 16'hFF00;
  localparam logic [WORD_W-1:0] SR_LAST_WORD_MASK = 16'h00FF;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] FULL_MASK = 16'hFFFF;

  typedef enum logic [2:0] {
    AREA_PLAIN,
    AREA_AUX,
    AREA_DATA,
    AREA_HOLD,
    AREA_LINK,
    AREA_TIMER,
    AREA_TEMP
  } dam_area_type;

  typedef enum logic [2:0] {
    OP_LOAD_BIT,
    OP_OUT_BIT,
    OP_READ_BIT,
    OP_WRITE_BIT,
    OP_READ_WORD,
    OP_WRITE_WORD
  } dam_op_type;
endpackage

// ===== src/dam_word_bank.sv
/*
 * Flip-flop word bank with masked write and combinational indexed read.
 * Assumes the index is in range whenever the write enable is high.
 */
`timescale 1ns/1ps
module dam_word_bank #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [IDX_W-1:0] i_idx,
  input wire logic [dam_pkg::WORD_W-1:0] i_wmask,
  input wire logic [dam_pkg::WORD_W-1:0] i_wdata,
  input wire logic [IDX_W-1:0] i_ridx,
  output logic [dam_pkg::WORD_W-1:0] o_rdata
);
  import dam_pkg::*;

  logic [WORD_W-1:0] mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      wire hit = i_we && (i_idx == IDX_W'(g));
      always_ff @(posedge i_clk) begin
        if (i_clear) begin
          mem[g] <= WORD_RESET;
        end else if (hit) begin
          mem[g] <= (mem[g] & ~i_wmask) | (i_wdata & i_wmask);
        end
      end
    end
  endgenerate

  assign o_rdata = (int'(i_ridx) < DEPTH) ? mem[i_ridx] : WORD_RESET;
endmodule
